// File: rtl/radio_core_irq_pkg.sv
// constants, field layout and carrier types for the radio core
// interrupt acknowledge and time reference snapshot block.
// assumes a single 10 MHz bus clock shared by all users.
package radio_core_irq_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_MASKED_STAT = 32'h4000_0010;
  localparam logic [ADDR_W-1:0] ADDR_RAW_STAT = 32'h4000_0014;
  localparam logic [ADDR_W-1:0] ADDR_ACK = 32'h4000_0018;
  localparam logic [ADDR_W-1:0] ADDR_BASE_SNAP = 32'h4000_001C;
  localparam logic [ADDR_W-1:0] ADDR_FINE_SNAP = 32'h4000_0020;

  // field widths
  localparam int unsigned NUM_SRC = 10;
  localparam int unsigned BASE_W = 27;
  localparam int unsigned FINE_W = 10;

  // interrupt source bit positions
  localparam int unsigned SRC_TICK = 0;
  localparam int unsigned SRC_RECEIVE = 1;
  localparam int unsigned SRC_SLEEP_END = 2;
  localparam int unsigned SRC_END_EVENT = 3;
  localparam int unsigned SRC_CIPHER = 4;
  localparam int unsigned SRC_ERROR = 5;
  localparam int unsigned SRC_GROSS_TARGET = 6;
  localparam int unsigned SRC_FINE_TARGET = 7;
  localparam int unsigned SRC_EVENT_ABORT = 8;
  localparam int unsigned SRC_SOFT = 9;

  // reset values
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 10'h000;
  localparam logic [NUM_SRC-1:0] ACK_READ_VALUE = 10'h000;
  localparam logic [BASE_W-1:0] BASE_RESET = 27'h000_0000;
  localparam logic [FINE_W-1:0] FINE_RESET = 10'h000;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned SLOT_US = 625;
  localparam int unsigned CYC_PER_US = US_NS / CLK_PERIOD_NS;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MASKED,
    SEL_RAW,
    SEL_ACK,
    SEL_BASE,
    SEL_FINE
  } reg_sel_t;

  // one register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // time reference pair
  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [FINE_W-1:0] fine;
  } time_snap_t;

endpackage : radio_core_irq_pkg

// File: rtl/radio_core_timebase.sv
// free running time reference: microsecond fine count within a
// 625 us slot and a base count of whole slots.
// assumes the 10 MHz bus clock and a synchronous active-low reset.
module radio_core_timebase #(
  parameter int unsigned BASE_W = radio_core_irq_pkg::BASE_W,
  parameter int unsigned FINE_W = radio_core_irq_pkg::FINE_W,
  parameter int unsigned CYC_PER_US = radio_core_irq_pkg::CYC_PER_US,
  parameter int unsigned SLOT_US = radio_core_irq_pkg::SLOT_US
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // time reference
  output radio_core_irq_pkg::time_snap_t o_time,
  output logic o_tick
);

  localparam int unsigned PRE_W = $clog2(CYC_PER_US + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
  localparam logic [FINE_W-1:0] FINE_LAST = FINE_W'(SLOT_US - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;
  localparam logic [FINE_W-1:0] FINE_ZERO = '0;
  localparam logic [BASE_W-1:0] BASE_ZERO = '0;
  localparam logic [BASE_W-1:0] BASE_ONE = BASE_W'(1);
  localparam logic [FINE_W-1:0] FINE_ONE = FINE_W'(1);
  localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);

  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic [FINE_W-1:0] fine_reg;
  logic [FINE_W-1:0] fine_next;
  logic [BASE_W-1:0] base_reg;
  logic [BASE_W-1:0] base_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    pre_next = pre_reg;
    fine_next = fine_reg;
    base_next = base_reg;
    tick_next = 1'b0;
    if (pre_reg == PRE_LAST) begin
      pre_next = PRE_ZERO;
      if (fine_reg == FINE_LAST) begin
        // base count wraps silently after 2^27 slots
        fine_next = FINE_ZERO;
        base_next = base_reg + BASE_ONE;
        tick_next = 1'b1;
      end else begin
        fine_next = fine_reg + FINE_ONE;
      end
    end else begin
      pre_next = pre_reg + PRE_ONE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pre_reg <= PRE_ZERO;
      fine_reg <= FINE_ZERO;
      base_reg <= BASE_ZERO;
      tick_reg <= 1'b0;
    end else if (i_ce) begin
      pre_reg <= pre_next;
      fine_reg <= fine_next;
      base_reg <= base_next;
      tick_reg <= tick_next;
    end
  end

  assign o_time.base = base_reg;
  assign o_time.fine = fine_reg;
  assign o_tick = tick_reg;

endmodule : radio_core_timebase

// File: rtl/radio_core_irq_ack_timebase.sv
// radio core interrupt pending flags with write-one acknowledge,
// plus sampled copies of the slot and microsecond time counts.
// assumes sources pulse i_irq_set synchronously to i_clk_sys and
// software pulses i_sample_trigger when it writes the sample bit.
// Notes on behaviour
// RULE1 - bit 9 clears soft interrupt flags
// RULE2 - bit 8 clears event abort flags
// RULE3 - bit 7 clears fine target flags
// RULE4 - bit 6 clears gross target flags
// RULE5 - bit 5 clears error flags
// RULE6 - bit 4 clears cipher flags
// RULE7 - bit 3 acknowledges end of event
// RULE8 - bit 2 clears end of sleep flags
// RULE9 - bit 0 clears 625 us tick flags
// RULE10 - acknowledge bits self clear, read zero
// RULE11 - base count snapshot on sample trigger
// RULE12 - fine count snapshot on sample trigger
// RULE13 - raw and enable-gated masked flag per source
// RULE14 - zero writes ignored; bit 3 clears end-event
//
// The address-and-strobe port was decided locally.
module radio_core_irq_ack_timebase #(
  parameter int unsigned NUM_SRC = radio_core_irq_pkg::NUM_SRC
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // register port
  input wire logic [radio_core_irq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [radio_core_irq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [radio_core_irq_pkg::DATA_W-1:0] o_rdata,
  // interrupt sources and enables
  input wire logic [NUM_SRC-1:0] i_irq_set,
  input wire logic [NUM_SRC-1:0] i_irq_enable,
  input wire logic i_sample_trigger,
  // pending flags
  output logic [NUM_SRC-1:0] o_irq_raw,
  output logic [NUM_SRC-1:0] o_irq_masked
);

  localparam int unsigned DW = radio_core_irq_pkg::DATA_W;
  localparam int unsigned BW = radio_core_irq_pkg::BASE_W;
  localparam int unsigned FW = radio_core_irq_pkg::FINE_W;

  // address decode, shared by the write and read paths
  function automatic radio_core_irq_pkg::reg_sel_t decode_addr(
    input logic [radio_core_irq_pkg::ADDR_W-1:0] addr
  );
    radio_core_irq_pkg::reg_sel_t sel;
    case (addr)
      radio_core_irq_pkg::ADDR_MASKED_STAT: sel = radio_core_irq_pkg::SEL_MASKED;
      radio_core_irq_pkg::ADDR_RAW_STAT: sel = radio_core_irq_pkg::SEL_RAW;
      radio_core_irq_pkg::ADDR_ACK: sel = radio_core_irq_pkg::SEL_ACK;
      radio_core_irq_pkg::ADDR_BASE_SNAP: sel = radio_core_irq_pkg::SEL_BASE;
      radio_core_irq_pkg::ADDR_FINE_SNAP: sel = radio_core_irq_pkg::SEL_FINE;
      default: sel = radio_core_irq_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // zero-extend a narrow field into a bus word
  function automatic logic [DW-1:0] widen_flags(
    input logic [NUM_SRC-1:0] flags
  );
    logic [DW-1:0] word;
    word = '0;
    word[NUM_SRC-1:0] = flags;
    return word;
  endfunction : widen_flags

  radio_core_irq_pkg::bus_req_t req;
  radio_core_irq_pkg::reg_sel_t wr_sel;
  radio_core_irq_pkg::reg_sel_t rd_sel;
  radio_core_irq_pkg::time_snap_t live_time;
  logic live_tick;

  logic [NUM_SRC-1:0] ack_pulse;
  logic [NUM_SRC-1:0] clr_vec;
  logic [NUM_SRC-1:0] set_vec;

  logic [NUM_SRC-1:0] raw_reg;
  logic [NUM_SRC-1:0] raw_next;
  logic [NUM_SRC-1:0] masked_reg;
  logic [NUM_SRC-1:0] masked_next;
  radio_core_irq_pkg::time_snap_t snap_reg;
  radio_core_irq_pkg::time_snap_t snap_next;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  assign req.addr = i_addr;
  assign req.wdata = i_wdata;
  assign req.wr = i_wr;
  assign req.rd = i_rd;
  assign wr_sel = decode_addr(req.addr);
  assign rd_sel = decode_addr(req.addr);

  radio_core_timebase #(
    .BASE_W(BW),
    .FINE_W(FW),
    .CYC_PER_US(radio_core_irq_pkg::CYC_PER_US),
    .SLOT_US(radio_core_irq_pkg::SLOT_US)
  ) u_timebase (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .o_time(live_time),
    .o_tick(live_tick)
  );

  // acknowledge is a strobe, never stored, so nothing lingers
  always_comb begin
    ack_pulse = '0;
    if (req.wr && (wr_sel == radio_core_irq_pkg::SEL_ACK)) begin
      ack_pulse = req.wdata[NUM_SRC-1:0]; // RULE10
    end
  end

  // per-source clear terms; a zero bit leaves its flags alone
  always_comb begin
    clr_vec = '0; // RULE14
    clr_vec[radio_core_irq_pkg::SRC_SOFT] =
      ack_pulse[radio_core_irq_pkg::SRC_SOFT]; // RULE1
    clr_vec[radio_core_irq_pkg::SRC_EVENT_ABORT] =
      ack_pulse[radio_core_irq_pkg::SRC_EVENT_ABORT]; // RULE2
    clr_vec[radio_core_irq_pkg::SRC_FINE_TARGET] =
      ack_pulse[radio_core_irq_pkg::SRC_FINE_TARGET]; // RULE3
    clr_vec[radio_core_irq_pkg::SRC_GROSS_TARGET] =
      ack_pulse[radio_core_irq_pkg::SRC_GROSS_TARGET]; // RULE4
    clr_vec[radio_core_irq_pkg::SRC_ERROR] =
      ack_pulse[radio_core_irq_pkg::SRC_ERROR]; // RULE5
    clr_vec[radio_core_irq_pkg::SRC_CIPHER] =
      ack_pulse[radio_core_irq_pkg::SRC_CIPHER]; // RULE6
    // end-event acknowledge hits its own flags, not the sleep ones
    clr_vec[radio_core_irq_pkg::SRC_END_EVENT] =
      ack_pulse[radio_core_irq_pkg::SRC_END_EVENT]; // RULE7 RULE14
    clr_vec[radio_core_irq_pkg::SRC_SLEEP_END] =
      ack_pulse[radio_core_irq_pkg::SRC_SLEEP_END]; // RULE8
    clr_vec[radio_core_irq_pkg::SRC_RECEIVE] =
      ack_pulse[radio_core_irq_pkg::SRC_RECEIVE];
    clr_vec[radio_core_irq_pkg::SRC_TICK] =
      ack_pulse[radio_core_irq_pkg::SRC_TICK]; // RULE9
  end

  // the slot tick is raised locally as well as by its input
  always_comb begin
    set_vec = i_irq_set;
    set_vec[radio_core_irq_pkg::SRC_TICK] =
      i_irq_set[radio_core_irq_pkg::SRC_TICK] | live_tick;
  end

  // a set arriving with its acknowledge wins, so no event is lost
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_flag
      always_comb begin
        raw_next[g] = set_vec[g] | (raw_reg[g] & ~clr_vec[g]); // RULE13
        masked_next[g] = raw_next[g] & i_irq_enable[g]; // RULE13
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      raw_reg <= radio_core_irq_pkg::FLAGS_RESET;
      masked_reg <= radio_core_irq_pkg::FLAGS_RESET;
    end else if (i_ce) begin
      raw_reg <= raw_next;
      masked_reg <= masked_next;
    end
  end

  // snapshot of both counts taken together, so they stay coherent
  always_comb begin
    snap_next = snap_reg;
    if (i_sample_trigger) begin
      snap_next.base = live_time.base; // RULE11
      snap_next.fine = live_time.fine; // RULE12
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      snap_reg.base <= radio_core_irq_pkg::BASE_RESET;
      snap_reg.fine <= radio_core_irq_pkg::FINE_RESET;
    end else if (i_ce) begin
      snap_reg <= snap_next;
    end
  end

  // read data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = radio_core_irq_pkg::RDATA_IDLE;
    if (req.rd) begin
      case (rd_sel)
        radio_core_irq_pkg::SEL_MASKED: rdata_next = widen_flags(masked_reg);
        radio_core_irq_pkg::SEL_RAW: rdata_next = widen_flags(raw_reg);
        radio_core_irq_pkg::SEL_ACK: begin
          rdata_next = widen_flags(radio_core_irq_pkg::ACK_READ_VALUE); // RULE10
        end
        radio_core_irq_pkg::SEL_BASE: begin
          rdata_next = '0;
          rdata_next[BW-1:0] = snap_reg.base; // RULE11
        end
        radio_core_irq_pkg::SEL_FINE: begin
          rdata_next = '0;
          rdata_next[FW-1:0] = snap_reg.fine; // RULE12
        end
        default: rdata_next = radio_core_irq_pkg::RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rdata_reg <= radio_core_irq_pkg::RDATA_IDLE;
    end else if (i_ce) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq_raw = raw_reg;
  assign o_irq_masked = masked_reg;

endmodule : radio_core_irq_ack_timebase

// File: bench/radio_core_irq_ack_timebase_chk.sv
// checker for the acknowledge and snapshot block
// assumes it is bound to the block and sees its ports only
module radio_core_irq_ack_timebase_chk #(
  parameter int unsigned NUM_SRC = radio_core_irq_pkg::NUM_SRC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // register port
  input wire logic [radio_core_irq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [radio_core_irq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [radio_core_irq_pkg::DATA_W-1:0] o_rdata,
  // sources and flags
  input wire logic [NUM_SRC-1:0] i_irq_set,
  input wire logic [NUM_SRC-1:0] i_irq_enable,
  input wire logic i_sample_trigger,
  input wire logic [NUM_SRC-1:0] o_irq_raw,
  input wire logic [NUM_SRC-1:0] o_irq_masked
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_ack_wr;
    i_ce && i_wr && i_addr == radio_core_irq_pkg::ADDR_ACK;
  endsequence
  sequence s_rd(a);
    i_ce && i_rd && i_addr == a;
  endsequence
  // bit 0 left out: the internal tick may set it unseen
  a_ack_clears: assert property (s_ack_wr |=> ((o_irq_raw | o_irq_masked)
    & $past(i_wdata[NUM_SRC-1:0] & ~i_irq_set) & 10'h3FE) == '0)
    else $error("acknowledged flag still set");
  a_tick_ack: assert property (s_ack_wr ##0 i_wdata[0] |=> !o_irq_raw[0])
    else $error("tick flag not cleared");
  a_zero_keeps: assert property (s_ack_wr |=>
    (o_irq_raw & $past(o_irq_raw & ~i_wdata[NUM_SRC-1:0]))
    == $past(o_irq_raw & ~i_wdata[NUM_SRC-1:0]))
    else $error("zero write cleared a flag");
  a_set_wins: assert property (i_ce |=>
    (o_irq_raw & $past(i_irq_set)) == $past(i_irq_set))
    else $error("set pulse not captured");
  a_mask_gate: assert property (i_ce |=>
    o_irq_masked == (o_irq_raw & $past(i_irq_enable)))
    else $error("masked flags wrong");
  a_raw_stays: assert property (i_ce && !i_wr && i_irq_set == '0 |=>
    $stable(o_irq_raw[NUM_SRC-1:1]))
    else $error("raw flag changed without cause");
  a_ack_reads_zero: assert property (
    s_rd(radio_core_irq_pkg::ADDR_ACK) |=> o_rdata == '0)
    else $error("acknowledge register read nonzero");
  a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == '0)
    else $error("read data outside read cycle");
  a_base_width: assert property (
    s_rd(radio_core_irq_pkg::ADDR_BASE_SNAP) |=> o_rdata[31:27] == '0)
    else $error("base snapshot too wide");
  a_fine_range: assert property (
    s_rd(radio_core_irq_pkg::ADDR_FINE_SNAP) |=> o_rdata < 32'h271)
    else $error("fine snapshot out of range");
endmodule : radio_core_irq_ack_timebase_chk

bind radio_core_irq_ack_timebase radio_core_irq_ack_timebase_chk #(
  .NUM_SRC(NUM_SRC)) i_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_set(i_irq_set),
  .i_irq_enable(i_irq_enable), .i_sample_trigger(i_sample_trigger),
  .o_irq_raw(o_irq_raw), .o_irq_masked(o_irq_masked));

// File: bench/radio_core_irq_ack_timebase_bench.sv
// self-checking bench for the acknowledge and snapshot block
// assumes the block alone, driven straight through its ports
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s expected %h seen %h", nm, e, g); end end
module radio_core_irq_ack_timebase_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned N = radio_core_irq_pkg::NUM_SRC;
  logic i_clk_sys, i_rst_b, i_ce, i_wr, i_rd, i_sample_trigger;
  logic [31:0] i_addr, i_wdata, o_rdata, rd_q, snap_b, snap_f;
  logic [N-1:0] i_irq_set, i_irq_enable, o_irq_raw, o_irq_masked;
  logic [31:0] regs [6];
  int err_total, cmp_count;
  radio_core_irq_ack_timebase i_radio_core_irq_ack_timebase (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_irq_set(i_irq_set),
    .i_irq_enable(i_irq_enable), .i_sample_trigger(i_sample_trigger),
    .o_irq_raw(o_irq_raw), .o_irq_masked(o_irq_masked));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
  endtask : rd
  task automatic pulse(input logic [N-1:0] s, input logic t);
    @(posedge i_clk_sys);
    i_irq_set <= s;
    i_sample_trigger <= t;
    @(posedge i_clk_sys);
    i_irq_set <= '0;
    i_sample_trigger <= 1'b0;
  endtask : pulse
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    regs = '{radio_core_irq_pkg::ADDR_MASKED_STAT,
      radio_core_irq_pkg::ADDR_RAW_STAT, radio_core_irq_pkg::ADDR_ACK,
      radio_core_irq_pkg::ADDR_BASE_SNAP,
      radio_core_irq_pkg::ADDR_FINE_SNAP, 32'h4000_0024};
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    {i_wr, i_rd, i_sample_trigger} = 3'h0;
    i_addr = 32'h0000_0000;
    i_wdata = 32'h0000_0000;
    i_irq_set = '0;
    // odd sources enabled, so masked and raw differ
    i_irq_enable = 10'h2AA;
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      `CHK("reset read", 32'h0000_0000, rd_q)
    end
    for (int k = 1; k < N; k++) begin
      pulse(N'(1 << k), 1'b0);
      rd(radio_core_irq_pkg::ADDR_RAW_STAT);
      `CHK("raw set", 32'(1 << k), rd_q & 32'h0000_03FE)
      rd(radio_core_irq_pkg::ADDR_MASKED_STAT);
      `CHK("masked set", 32'(1 << k) & 32'h0000_02AA, rd_q)
      wr(radio_core_irq_pkg::ADDR_ACK, 32'h0000_0000);
      `CHK("zero write", N'(1 << k), o_irq_raw & 10'h3FE)
      wr(radio_core_irq_pkg::ADDR_ACK, 32'(1 << k));
      `CHK("ack raw", 10'h000, o_irq_raw & 10'h3FE)
      `CHK("ack masked", 10'h000, o_irq_masked)
    end
    pulse('0, 1'b1);
    rd(radio_core_irq_pkg::ADDR_BASE_SNAP);
    snap_b = rd_q;
    rd(radio_core_irq_pkg::ADDR_FINE_SNAP);
    snap_f = rd_q;
    // second sample lands 6650 cycles after the first: 665 us later
    repeat (6644) @(posedge i_clk_sys);
    pulse('0, 1'b1);
    rd(radio_core_irq_pkg::ADDR_BASE_SNAP);
    snap_b = rd_q * 32'h271 - snap_b * 32'h271;
    `CHK("base upper", 5'h00, rd_q[31:27])
    rd(radio_core_irq_pkg::ADDR_FINE_SNAP);
    `CHK("time step", 32'h0000_0299, snap_b + rd_q - snap_f)
    `CHK("tick raw", 1'b1, o_irq_raw[0])
    wr(32'h4000_0024, 32'h0000_0001);
    `CHK("unmapped write", 1'b1, o_irq_raw[0])
    wr(radio_core_irq_pkg::ADDR_ACK, 32'h0000_0001);
    `CHK("tick ack", 1'b0, o_irq_raw[0])
    // low clock enable must hold every flag, set pulses included
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    pulse(10'h002, 1'b0);
    #1 `CHK("frozen raw", 10'h000, o_irq_raw)
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    wrap_up();
  end
endmodule : radio_core_irq_ack_timebase_bench
